// *** design/adc_serial_ctrl.v ***
// Convert command handling, conversion sequencing and serial output of an 18-bit sampling converter
`timescale 1ns/10ps
`include "adc_serial_regs.vh"

// Operation
// - Convert falling edge puts input into hold
// - Same edge converts and sends previous result
// - One bit-clock-period sync pulse per command
// - Sync polarity follows polarity select
// - Results sent MSB first, two's complement
// - Tag level shifted out after 18 bits, after 34 on line A in cascade
// - Load on bit clock rise, later rises shift
// - New command latches input shift register
// - Commands accepted with no phase relation
// - Conversion clock independent of bit clock
// - Output, sync and tags retimed to bit clock
// - One command samples both channels together
// - Cascade line: 16 A bits then 18 B
// - Return to sampling after conversion ends
// - Codes two's complement, 1FFFF to 20000
// - Channel B line unchanged in cascade mode
// - Conversion clock out is oscillator divided by three
// - Tags enter shift register, appear 18 later, 34 later on line A in cascade
module adc_serial_ctrl
(
	input  wire        sys_clk_i,                // System clock, 250 MHz
	input  wire        rst_i,                    // Asynchronous reset, active high
	input  wire        convert_command_n_i,      // Convert command, falling edge acts
	input  wire        bit_clock_i,              // Serial bit clock, sampled
	input  wire        conversion_clock_in_i,    // Conversion clock, sampled
	input  wire        oscillator_in_i,          // Oscillator or external clock, sampled
	input  wire        tag_in_chan_a_i,          // Channel A tag data
	input  wire        tag_in_chan_b_i,          // Channel B tag data
	input  wire        sar_bit_a_i,              // Channel A bit decision from analog core
	input  wire        sar_bit_b_i,              // Channel B bit decision from analog core
	input  wire [7:0]  paddr,                    // APB address
	input  wire        psel,                     // APB select
	input  wire        penable,                  // APB enable
	input  wire        pwrite,                   // APB write
	input  wire [31:0] pwdata,                   // APB write data
	output wire [31:0] prdata,                   // APB read data
	output wire        pready,                   // APB ready
	output wire        pslverr,                  // APB error, unmapped address
	output wire        sample_hold_o,            // High holds the sampling capacitors
	output wire        conversion_clock_out_o,   // Oscillator divided by three
	output wire        sync_o,                   // Frame sync
	output wire        serial_out_chan_a_o,      // Channel A serial data
	output wire        serial_out_chan_b_o       // Channel B serial data
);

	localparam RB = `RESULT_BITS;
	localparam CB = `CASCADE_BITS;

	// Conversion sequencer states, one-hot
	localparam [1:0] ST_TRACK = 2'b01;
	localparam [1:0] ST_CONVERT_COMMAND_N  = 2'b10;

	reg  [2:0]    convert_command_n_sync_ff;
	reg           bclk_ff;
	reg           cclk_ff;
	reg           osc_ff;
	reg  [1:0]    div_cnt_ff;
	reg           cclk_out_ff;
	reg  [1:0]    state_ff;
	reg  [4:0]    convert_command_n_cnt_ff;
	reg  [RB-1:0] in_a_ff;
	reg  [RB-1:0] in_b_ff;
	reg  [RB-1:0] lat_a_ff;
	reg  [RB-1:0] lat_b_ff;
	reg           load_pend_ff;
	reg           sync_act_ff;
	reg           sync_ff;
	reg  [CB-1:0] sh_a_ff;
	reg  [RB-1:0] sh_b_ff;
	reg  [1:0]    ctrl_ff;
	reg  [31:0]   prdata_ff;
	reg           pready_ff;
	reg           pslverr_ff;
	reg  [1:0]    nxt_state;
	reg  [CB-1:0] nxt_sh_a;

	wire convert_command_n_fall;
	wire bclk_rise;
	wire cclk_rise;
	wire osc_rise;
	wire sync_pol;
	wire cascade;
	wire setup_ph;
	wire wr_ctrl;

	// Address decode used by the error path only; reads decode in their own case
	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `CTRL_OFS) || (a == `STATUS_OFS) ||
				(a == `RESULT_A_OFS) || (a == `RESULT_B_OFS);
		end
	endfunction

	assign convert_command_n_fall = convert_command_n_sync_ff[2] & ~convert_command_n_sync_ff[1];
	assign bclk_rise = bit_clock_i & ~bclk_ff;
	assign cclk_rise = conversion_clock_in_i & ~cclk_ff;
	assign osc_rise  = oscillator_in_i & ~osc_ff;
	assign sync_pol  = ctrl_ff[`CTRL_SYNC_POL_BIT];
	assign cascade   = ctrl_ff[`CTRL_CASCADE_BIT];
	assign setup_ph  = psel & ~penable;
	assign wr_ctrl   = psel & penable & pready_ff & pwrite & (paddr == `CTRL_OFS);

	// Command is asynchronous, so only the last stage pair feeds the edge detector
	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			convert_command_n_sync_ff <= 3'h7;
		else
			convert_command_n_sync_ff <= {convert_command_n_sync_ff[1:0], convert_command_n_i};
	end

	// Previous levels for edge detection of the sampled clocks
	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			bclk_ff <= 1'b0;
			cclk_ff <= 1'b0;
			osc_ff  <= 1'b0;
		end
		else
		begin
			bclk_ff <= bit_clock_i;
			cclk_ff <= conversion_clock_in_i;
			osc_ff  <= oscillator_in_i;
		end
	end

	// Divide by three, high one count in three for a 33% duty clock
	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			div_cnt_ff  <= 2'h0;
			cclk_out_ff <= 1'b0;
		end
		else if (osc_rise)
		begin
			div_cnt_ff  <= (div_cnt_ff == `DIVIDE_BY - 2'h1) ? 2'h0 : div_cnt_ff + 2'h1;
			cclk_out_ff <= (div_cnt_ff == `DIVIDE_BY - 2'h2);
		end
	end

	// Sequencer next state
	always @*
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_TRACK:
				if (convert_command_n_fall)
					nxt_state = ST_CONVERT_COMMAND_N;
			ST_CONVERT_COMMAND_N:
				if (convert_command_n_fall)
					nxt_state = ST_CONVERT_COMMAND_N;
				else if (cclk_rise && convert_command_n_cnt_ff == RB - 1)
					nxt_state = ST_TRACK;
			default:
				nxt_state = ST_TRACK;
		endcase
	end

	// Conversion: both channels take bit decisions on the same conversion clock
	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_ff    <= ST_TRACK;
			convert_command_n_cnt_ff <= 5'h0;
			in_a_ff     <= {RB{1'b0}};
			in_b_ff     <= {RB{1'b0}};
			lat_a_ff    <= {RB{1'b0}};
			lat_b_ff    <= {RB{1'b0}};
		end
		else
		begin
			state_ff <= nxt_state;
			if (convert_command_n_fall)
			begin
				// A late command truncates the running conversion; spacing is the user's job
				lat_a_ff    <= in_a_ff;
				lat_b_ff    <= in_b_ff;
				convert_command_n_cnt_ff <= 5'h0;
			end
			else if (state_ff == ST_CONVERT_COMMAND_N && cclk_rise)
			begin
				in_a_ff     <= {in_a_ff[RB-2:0], sar_bit_a_i};
				in_b_ff     <= {in_b_ff[RB-2:0], sar_bit_b_i};
				convert_command_n_cnt_ff <= convert_command_n_cnt_ff + 5'h1;
			end
		end
	end

	// Channel A shift value; in cascade the B stream follows A's top 16 bits
	always @*
	begin
		nxt_sh_a = sh_a_ff;
		if (load_pend_ff)
		begin
			if (cascade)
				nxt_sh_a = {lat_a_ff[RB-1:RB-`CASCADE_A_BITS], lat_b_ff};
			else
				nxt_sh_a = {lat_a_ff, {`CASCADE_A_BITS{1'b0}}};
		end
		else if (cascade)
			nxt_sh_a = {sh_a_ff[CB-2:0], tag_in_chan_b_i};
		else
			nxt_sh_a = {sh_a_ff[CB-2:CB-RB], tag_in_chan_a_i, {`CASCADE_A_BITS{1'b0}}};
	end

	// Output side works only on bit clock rises; load pending bridges the command edge
	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			load_pend_ff <= 1'b0;
			sync_act_ff  <= 1'b0;
			sh_a_ff      <= {CB{1'b0}};
			sh_b_ff      <= {RB{1'b0}};
		end
		else
		begin
			if (convert_command_n_fall)
				load_pend_ff <= 1'b1;
			else if (bclk_rise)
				load_pend_ff <= 1'b0;
			if (bclk_rise)
			begin
				sync_act_ff <= load_pend_ff;
				sh_a_ff     <= nxt_sh_a;
				if (load_pend_ff)
					sh_b_ff <= lat_b_ff;
				else
					sh_b_ff <= {sh_b_ff[RB-2:0], tag_in_chan_b_i};
			end
		end
	end

	// Sync pin driven from a register so polarity change never glitches
	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			sync_ff <= 1'b0;
		else
			sync_ff <= ~(sync_act_ff ^ sync_pol);
	end

	// Control register, written only at the access edge that completes the transfer
	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			ctrl_ff <= `CTRL_RESET_VAL;
		else if (wr_ctrl)
			ctrl_ff <= pwdata[1:0];
	end

	// Read data prepared in setup so the access phase needs no wait state
	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			prdata_ff  <= 32'h0000_0000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff  <= setup_ph;
			pslverr_ff <= setup_ph & ~mapped(paddr);
			if (setup_ph && !pwrite)
			begin
				case (paddr)
					`CTRL_OFS:     prdata_ff <= {30'h0000_0000, ctrl_ff};
					`STATUS_OFS:   prdata_ff <= {29'h0000_0000, load_pend_ff, state_ff[1], state_ff[1]};
					`RESULT_A_OFS: prdata_ff <= {14'h0000, lat_a_ff};
					`RESULT_B_OFS: prdata_ff <= {14'h0000, lat_b_ff};
					default:       prdata_ff <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign prdata                 = prdata_ff;
	assign pready                 = pready_ff;
	assign pslverr                = pslverr_ff;
	assign sample_hold_o          = state_ff[1];
	assign conversion_clock_out_o = cclk_out_ff;
	assign sync_o                 = sync_ff;
	assign serial_out_chan_a_o    = sh_a_ff[CB-1];
	assign serial_out_chan_b_o    = sh_b_ff[RB-1];

endmodule // adc_serial_ctrl

// *** design/adc_serial_regs.vh ***
// Register offsets, field positions, reset values and widths of the converter control block
`ifndef ADC_SERIAL_REGS_VH
`define ADC_SERIAL_REGS_VH

// Register byte offsets on the APB
`define CTRL_OFS          8'h00
`define STATUS_OFS        8'h04
`define RESULT_A_OFS      8'h08
`define RESULT_B_OFS      8'h0C

// Control register fields
`define CTRL_SYNC_POL_BIT 0
`define CTRL_CASCADE_BIT  1
`define CTRL_RESET_VAL    2'h1

// Status register fields
`define STAT_BUSY_BIT     0
`define STAT_HOLD_BIT     1
`define STAT_LOAD_BIT     2

// Data widths and counts
`define RESULT_BITS       18
`define CASCADE_A_BITS    16
`define CASCADE_BITS      34
`define DIVIDE_BY         2'h3

`endif

// *** verification/adc_serial_ctrl_asserts.sv ***
// Port-level checks of the converter control block
`timescale 1ns/10ps
module adc_serial_ctrl_asserts
(
	input wire sys_clk_i,              // Clock
	input wire rst_i,                  // Reset
	input wire convert_command_n_i,    // Convert command
	input wire bit_clock_i,            // Bit clock
	input wire psel,                   // APB select
	input wire pwrite,                 // APB write
	input wire sample_hold_o,          // Hold
	input wire conversion_clock_out_o, // Divided clock
	input wire sync_o,                 // Frame sync
	input wire serial_out_chan_a_o,    // Line A
	input wire serial_out_chan_b_o     // Line B
);
	reg       bit_q_ff;    // Last bit clock level
	reg [3:0] rise_age_ff; // Cycles since bit clock rise
	reg [3:0] wr_age_ff;   // Cycles since a write setup
	// Saturating ages; a polarity write may move sync off a rise
	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			bit_q_ff <= 1'b0;
			rise_age_ff <= 4'hf;
			wr_age_ff <= 4'hf;
		end
		else
		begin
			bit_q_ff <= bit_clock_i;
			rise_age_ff <= (bit_clock_i && !bit_q_ff) ? 4'h0 : rise_age_ff + {3'h0, rise_age_ff != 4'hf};
			wr_age_ff <= (psel && pwrite) ? 4'h0 : wr_age_ff + {3'h0, wr_age_ff != 4'hf};
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	a_hold_on_convert_command_n: assert property ($fell(convert_command_n_i) |-> ##[1:6] sample_hold_o)
		else $error("hold not taken after convert");
	a_hold_release: assert property ($rose(sample_hold_o) |-> ##[96:130] $fell(sample_hold_o))
		else $error("hold not released after conversion");
	a_div_three: assert property ($rose(conversion_clock_out_o) |-> ##6 $rose(conversion_clock_out_o))
		else $error("divided clock period wrong");
	a_sync_after_convert_command_n: assert property ($fell(convert_command_n_i) |-> (!$changed(sync_o)) [*3] ##[1:40] $changed(sync_o))
		else $error("sync timing after convert wrong");
	a_line_a_timed: assert property ($changed(serial_out_chan_a_o) |-> rise_age_ff <= 4'h6)
		else $error("line a changed off a bit clock rise");
	a_line_b_timed: assert property ($changed(serial_out_chan_b_o) |-> rise_age_ff <= 4'h6)
		else $error("line b changed off a bit clock rise");
	a_sync_timed: assert property ($changed(sync_o) |-> rise_age_ff <= 4'h6 || wr_age_ff <= 4'h4)
		else $error("sync changed off a bit clock rise");
	a_sync_reset: assert property ($fell(rst_i) |-> !sync_o)
		else $error("sync not inactive after reset");
endmodule // adc_serial_ctrl_asserts

bind adc_serial_ctrl adc_serial_ctrl_asserts u_chk (.sys_clk_i, .rst_i, .convert_command_n_i, .bit_clock_i,
	.psel, .pwrite, .sample_hold_o, .conversion_clock_out_o, .sync_o, .serial_out_chan_a_o, .serial_out_chan_b_o);

// *** verification/dsp_serial_port_model.sv ***
// Serial input port model: makes the bit clock and captures one frame
`timescale 1ns/10ps
module dsp_serial_port_model
(
	input  wire        sys_clk_i,   // Clock
	input  wire        pol_i,       // Sync active level
	input  wire        sync_i,      // Frame sync
	input  wire        line_a_i,    // Line A
	input  wire        line_b_i,    // Line B
	output reg         bit_clock_o, // Bit clock, 16 cycles
	output reg  [39:0] word_a_o,    // Frame on line A
	output reg  [39:0] word_b_o,    // Frame on line B
	output reg  [3:0]  run_o        // Sync length in bits
);
	reg [2:0] ph_ff; // Half period phase
	reg [5:0] n_ff;  // Bits captured
	initial
	begin
		ph_ff = 3'h0;
		n_ff = 6'h28;
		bit_clock_o = 1'b0;
	end
	// Sample on the bit clock fall, mid-bit, clear of output latency
	always @(posedge sys_clk_i)
	begin
		ph_ff <= ph_ff + 3'h1;
		if (ph_ff == 3'h7)
			bit_clock_o <= !bit_clock_o;
		if (ph_ff == 3'h7 && bit_clock_o && sync_i == pol_i)
		begin
			run_o <= (n_ff == 6'h01) ? run_o + 4'h1 : 4'h1;
			n_ff <= 6'h01;
			word_a_o <= {39'h0, line_a_i};
			word_b_o <= {39'h0, line_b_i};
		end
		else if (ph_ff == 3'h7 && bit_clock_o && n_ff != 6'h28)
		begin
			n_ff <= n_ff + 6'h01;
			word_a_o <= {word_a_o[38:0], line_a_i};
			word_b_o <= {word_b_o[38:0], line_b_i};
		end
	end
endmodule // dsp_serial_port_model

// *** verification/sampling_adc_serial_output_test.sv ***
// Bench: register reads, frames, cascade packing and sync polarity
`timescale 1ns/10ps
module sampling_adc_serial_output_test;
	reg         clk = 1'b0, rst = 1'b1, convert_command_n_n = 1'b1, osc = 1'b0, pol = 1'b1, cc_q = 1'b0, cc_seen = 1'b0;
	reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg  [7:0]  paddr = 8'h00;
	reg  [31:0] pwdata = 32'h0000_0000;
	reg  [17:0] sar_a = 18'h0, sar_b = 18'h0, next_a = 18'h0, next_b = 18'h0, pa = 18'h0, pb = 18'h0;
	reg  [39:0] rd;
	wire [31:0] prdata;
	wire [39:0] word_a, word_b;
	wire [3:0]  run;
	wire        pready, pslverr, hold, cco, sync, sa, sb, bclk;
	integer     n_mismatch = 0, compares = 0;
	adc_serial_ctrl u_dut (.sys_clk_i(clk), .rst_i(rst), .convert_command_n_i(convert_command_n_n), .bit_clock_i(bclk),
		.conversion_clock_in_i(cco), .oscillator_in_i(osc), .tag_in_chan_a_i(1'b1), .tag_in_chan_b_i(1'b0),
		.sar_bit_a_i(sar_a[17]), .sar_bit_b_i(sar_b[17]), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_hold_o(hold), .conversion_clock_out_o(cco), .sync_o(sync), .serial_out_chan_a_o(sa),
		.serial_out_chan_b_o(sb));
	dsp_serial_port_model u_port (.sys_clk_i(clk), .pol_i(pol), .sync_i(sync), .line_a_i(sa), .line_b_i(sb),
		.bit_clock_o(bclk), .word_a_o(word_a), .word_b_o(word_b), .run_o(run));
	initial forever #2 clk = !clk;
	// Analog core stand-in: next bit on each conversion clock fall after the first rise
	always @(posedge clk)
	begin
		osc <= !osc;
		cc_q <= cco;
		if (!hold)
			{sar_a, sar_b, cc_seen} <= {next_a, next_b, 1'b0};
		else if (cco && !cc_q)
			cc_seen <= 1'b1;
		else if (!cco && cc_q && cc_seen)
			{sar_a, sar_b} <= {sar_a << 1, sar_b << 1};
	end
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
			@(posedge clk);
			penable <= 1'b1;
			@(posedge clk);
			while (pready !== 1'b1)
				@(posedge clk);
			rd = {7'h0, pslverr, prdata};
			{psel, penable} <= 2'b00;
			@(posedge clk);
		end
	endtask
	task chk(input [39:0] got, input [39:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp)
			begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected at %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// One command with new codes; checks the frame of the previous ones
	task step(input [1:0] c, input [17:0] a, input [17:0] b);
		begin
			apb(1'b1, 8'h00, {30'h0, c});
			{pol, next_a, next_b} <= {c[0], a, b};
			repeat (4) @(posedge clk);
			convert_command_n_n <= 1'b0;
			repeat (20) @(posedge clk);
			convert_command_n_n <= 1'b1;
			apb(1'b0, 8'h04, 32'h0);
			chk(rd & 40'h3, 40'h3);
			repeat (800) @(posedge clk);
			apb(1'b0, 8'h04, 32'h0);
			chk(rd, 40'h0);
			chk(word_a, c[1] ? {pa[17:2], pb, 6'h00} : {pa, 22'h3F_FFFF});
			chk(word_b, {pb, 22'h00_0000});
			chk({36'h0, run}, 40'h1);
			apb(1'b0, 8'h08, 32'h0);
			chk(rd, {22'h0, pa});
			apb(1'b0, 8'h0C, 32'h0);
			chk(rd, {22'h0, pb});
			{pa, pb} = {a, b};
			$display("test frame ctrl %h done", c);
		end
	endtask
	task tally_and_finish;
		begin
			$display("compares %0d mismatches %0d", compares, n_mismatch);
			if (n_mismatch == 0 && compares > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	initial
	begin
		#40000;
		n_mismatch = n_mismatch + 1;
		tally_and_finish;
	end
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 40'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 40'h01_0000_0000);
		$display("test reset done");
		step(2'h1, 18'h1_FFFF, 18'h2_0000);
		step(2'h1, 18'h3_FFFF, 18'h0_0000);
		step(2'h0, 18'h1_5555, 18'h0_AAAA);
		step(2'h3, 18'h2_AAAA, 18'h1_5555);
		step(2'h2, 18'h0_0000, 18'h3_FFFF);
		tally_and_finish;
	end
endmodule // sampling_adc_serial_output_test
